// ---- trap_entry_map.svh ----
`ifndef TRAP_ENTRY_MAP_SVH
`define TRAP_ENTRY_MAP_SVH

// register word indices (byte address = index * 4)
`define IDX_ICR        6'h00
`define IDX_TVB        6'h01
`define IDX_IVB        6'h02
`define IDX_FCX        6'h03
`define IDX_PREVIOUS_CONTEXT_INFO       6'h04
`define IDX_RA         6'h05
`define IDX_TID        6'h06
`define IDX_SRC        6'h07
`define IDX_STATE      6'h08
`define IDX_IRQ_STAT   6'h09
`define IDX_IRQ_CLR    6'h0a
`define IDX_IRQ_EN     6'h0b

// field positions
`define ICR_IE         8
`define PREVIOUS_CONTEXT_INFO_PIE       23
`define PREVIOUS_CONTEXT_INFO_PCPN_HI   31
`define PREVIOUS_CONTEXT_INFO_PCPN_LO   24
`define PREVIOUS_CONTEXT_INFO_LINK_HI   19
`define SRC_SET_REQUEST_BIT       15
`define VEC_SHIFT      5

// values
`define RST_WORD       32'h0000_0000
`define FCX_NULL       32'h0000_0000
`define TCN_NMI        32'h0000_00e0
`define CLASS_NMI      3'h7
`define CLASS_CTX      3'h3
`define TIN_NMI        8'h00
`define TIN_FCU        8'h00
`define TIN_WORD       4'hf
`define LAST_WORD      4'hf
`define EV_WIDTH       4

`endif

// ---- trap_entry_pkg.sv ----
package trap_entry_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAVE,
        ST_VECTOR,
        ST_FATAL
    } entry_state_t;

    typedef enum logic {
        KIND_TRAP,
        KIND_INT
    } entry_kind_t;
endpackage

// ---- sync_2ff.sv ----
`timescale 1ns/10ps
module sync_2ff (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_reg;

    // meta_reg feeds only the second stage
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= 1'b0;
            o_sync   <= 1'b0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule

// ---- sticky_irq.sv ----
`timescale 1ns/10ps
module sticky_irq #(
    parameter int W = 4
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_set,
    input  wire logic [W-1:0] i_clr,
    input  wire logic         i_en_wr,
    input  wire logic [W-1:0] i_en_data,
    output logic      [W-1:0] o_status,
    output logic      [W-1:0] o_enable,
    output logic              o_irq
);
    logic [W-1:0] status_next;

    // set wins over a clear in the same cycle
    assign status_next = (o_status & ~i_clr) | i_set;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_status <= '0;
            o_enable <= '0;
            o_irq    <= 1'b0;
        end else begin
            o_status <= status_next;
            if (i_en_wr) begin
                o_enable <= i_en_data;
            end
            o_irq <= |(status_next & (i_en_wr ? i_en_data : o_enable));
        end
    end
endmodule

// ---- trap_interrupt_entry_control.sv ----
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "trap_entry_map.svh"
module trap_interrupt_entry_control (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rst,
    // ahb-lite slave
    input  wire logic                        i_hsel,
    input  wire logic [31:0]                 i_haddr,
    input  wire logic [1:0]                  i_htrans,
    input  wire logic                        i_hwrite,
    input  wire logic [2:0]                  i_hsize,
    input  wire logic [31:0]                 i_hwdata,
    input  wire logic                        i_hready,
    output logic                             o_hreadyout,
    output logic                             o_hresp,
    output logic      [31:0]                 o_hrdata,
    // pipeline
    input  wire logic                        i_trap_req,
    input  wire logic [2:0]                  i_trap_class,
    input  wire logic [7:0]                  i_trap_tin,
    input  wire logic [4:0]                  i_trap_cause,
    input  wire logic                        i_ctx_fail,
    input  wire logic [31:0]                 i_epc,
    input  wire logic                        i_rfe,
    input  wire logic                        i_rfe_pie,
    input  wire logic [7:0]                  i_rfe_current_cpu_priority,
    input  wire logic [31:0]                 i_rfe_ret,
    input  wire logic [31:0]                 i_uctx_data,
    input  wire logic [31:0]                 i_csa_link,
    input  wire logic                        i_csa_err,
    input  wire logic                        i_nmi_pin,
    output logic      [3:0]                  o_uctx_idx,
    output logic                             o_csa_we,
    output logic      [31:0]                 o_csa_addr,
    output logic      [31:0]                 o_csa_wdata,
    output logic                             o_pc_load,
    output logic      [31:0]                 o_pc,
    output logic                             o_fatal,
    output trap_entry_pkg::entry_state_t     o_state,
    // interrupt router
    input  wire logic                        i_srq_req,
    input  wire logic [7:0]                  i_srq_prio,
    output logic                             o_int_ack,
    output logic                             o_irq
);
    import trap_entry_pkg::*;

    entry_state_t state_reg;
    entry_kind_t  kind_reg;
    logic         ie_reg;
    logic [7:0]   current_cpu_priority_reg;
    logic [31:0]  tvb_reg;
    logic [31:0]  ivb_reg;
    logic [31:0]  fcx_reg;
    logic [31:0]  previous_context_info_reg;
    logic [31:0]  ra_reg;
    logic [7:0]   tid_reg;
    logic         pend_reg;
    logic [7:0]   pend_prio_reg;
    logic [31:0]  off_reg;
    logic         fcu_reg;
    logic         imprecise_reg;
    logic         block_reg;
    logic [3:0]   idx_reg;
    logic         nmi_s;
    logic         nmi_d_reg;
    logic [5:0]   addr_q_reg;
    logic         wr_q_reg;
    logic         rd_q_reg;
    logic [31:0]  rd_mux;
    logic [`EV_WIDTH-1:0] ev_set;
    logic [`EV_WIDTH-1:0] ev_status;
    logic [`EV_WIDTH-1:0] ev_enable;

    ////////////////////////////////////////////////////////////////////////////
    // event detection and arbitration

    logic nmi_edge;
    logic trap_now;
    logic trap_entry;
    logic fcu_entry;
    logic save_fail;
    logic cause_hit;
    logic int_ok;
    logic ahb_take;
    logic src_set;

    sync_2ff u_nmi_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    (i_nmi_pin),
        .o_sync     (nmi_s)
    );

    assign nmi_edge   = nmi_s & ~nmi_d_reg;
    assign trap_now   = i_trap_req | nmi_edge | i_ctx_fail;
    assign trap_entry = (state_reg == ST_IDLE) & trap_now;
    assign fcu_entry  = trap_entry & (i_ctx_fail | (fcx_reg == `FCX_NULL));
    assign save_fail  = (state_reg == ST_SAVE) & i_csa_err;
    assign cause_hit  = (|i_trap_cause) | nmi_edge;
    // trap in this cycle or the one before, or a return, blocks acceptance
    assign int_ok = (state_reg == ST_IDLE) & ~trap_now & ~block_reg & ~i_rfe
                  & ie_reg & pend_reg & (pend_prio_reg > current_cpu_priority_reg);

    assign ahb_take = i_hsel & i_htrans[1] & i_hready;
    assign src_set  = wr_q_reg & (addr_q_reg == `IDX_SRC) & i_hwdata[`SRC_SET_REQUEST_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // entry sequencer

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            kind_reg  <= KIND_TRAP;
            idx_reg   <= 4'h0;
            off_reg   <= `RST_WORD;
            tid_reg   <= 8'h00;
            fcu_reg   <= 1'b0;
            nmi_d_reg <= 1'b0;
            block_reg <= 1'b0;
        end else begin
            nmi_d_reg <= nmi_s;
            block_reg <= trap_now | i_rfe;
            unique case (state_reg)
                ST_IDLE: begin
                    idx_reg <= 4'h0;
                    if (trap_entry) begin
                        kind_reg <= KIND_TRAP;
                        if (fcu_entry) begin
                            fcu_reg   <= 1'b1;
                            tid_reg   <= `TIN_FCU;
                            off_reg   <= 32'({`CLASS_CTX, 5'h00});
                            state_reg <= ST_VECTOR;
                        end else if (nmi_edge) begin
                            tid_reg   <= `TIN_NMI;
                            off_reg   <= `TCN_NMI;
                            state_reg <= ST_SAVE;
                        end else begin
                            tid_reg   <= i_trap_tin;
                            off_reg   <= 32'(i_trap_class) << `VEC_SHIFT;
                            state_reg <= ST_SAVE;
                        end
                    end else if (int_ok) begin
                        kind_reg  <= KIND_INT;
                        off_reg   <= 32'(pend_prio_reg) << `VEC_SHIFT;
                        state_reg <= ST_SAVE;
                    end
                end
                ST_SAVE: begin
                    idx_reg <= idx_reg + 4'h1;
                    if (save_fail) begin
                        fcu_reg   <= 1'b1;
                        kind_reg  <= KIND_TRAP;
                        tid_reg   <= `TIN_FCU;
                        off_reg   <= 32'({`CLASS_CTX, 5'h00});
                        state_reg <= ST_VECTOR;
                    end else if (idx_reg == `LAST_WORD) begin
                        state_reg <= ST_VECTOR;
                    end
                end
                ST_VECTOR: begin
                    state_reg <= fcu_reg ? ST_FATAL : ST_IDLE;
                end
                ST_FATAL: begin
                    state_reg <= ST_FATAL;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // context and pointer registers

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ie_reg        <= 1'b0;
            current_cpu_priority_reg      <= 8'h00;
            tvb_reg       <= `RST_WORD;
            ivb_reg       <= `RST_WORD;
            fcx_reg       <= `FCX_NULL;
            previous_context_info_reg      <= `RST_WORD;
            ra_reg        <= `RST_WORD;
            imprecise_reg <= 1'b0;
        end else begin
            if (trap_entry | int_ok) begin
                ie_reg                                  <= 1'b0;
                previous_context_info_reg[`PREVIOUS_CONTEXT_INFO_PIE]                     <= ie_reg;
                previous_context_info_reg[`PREVIOUS_CONTEXT_INFO_PCPN_HI:`PREVIOUS_CONTEXT_INFO_PCPN_LO]   <= current_cpu_priority_reg;
                previous_context_info_reg[`PREVIOUS_CONTEXT_INFO_LINK_HI:0]               <= fcx_reg[`PREVIOUS_CONTEXT_INFO_LINK_HI:0];
                ra_reg                                  <= i_epc;
                if (int_ok) begin
                    current_cpu_priority_reg <= pend_prio_reg;
                end
                if (fcu_entry) begin
                    imprecise_reg <= cause_hit;
                end
            end else if (save_fail) begin
                imprecise_reg <= imprecise_reg | (|i_trap_cause);
            end else if ((state_reg == ST_IDLE) & i_rfe) begin
                ie_reg   <= i_rfe_pie;
                current_cpu_priority_reg <= i_rfe_current_cpu_priority;
            end else if (wr_q_reg & (addr_q_reg == `IDX_ICR)) begin
                ie_reg   <= i_hwdata[`ICR_IE];
                current_cpu_priority_reg <= i_hwdata[7:0];
            end
            if ((state_reg == ST_SAVE) & ~save_fail & (idx_reg == `LAST_WORD)) begin
                fcx_reg <= i_csa_link; // consumed frame leaves the free list
            end else if (wr_q_reg & (addr_q_reg == `IDX_FCX)) begin
                fcx_reg <= i_hwdata;
            end
            if (wr_q_reg & (addr_q_reg == `IDX_TVB)) begin
                tvb_reg <= i_hwdata;
            end
            if (wr_q_reg & (addr_q_reg == `IDX_IVB)) begin
                ivb_reg <= i_hwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending service request (one slot; router requests keep the highest priority, a SRC write replaces it)

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_reg      <= 1'b0;
            pend_prio_reg <= 8'h00;
        end else begin
            // a new request in the accept cycle survives the clear
            if (src_set) begin
                pend_reg      <= 1'b1;
                pend_prio_reg <= i_hwdata[7:0];
            end else if (i_srq_req) begin
                pend_reg <= 1'b1;
                if (~pend_reg | int_ok | (i_srq_prio > pend_prio_reg)) begin
                    pend_prio_reg <= i_srq_prio;
                end
            end else if (int_ok) begin
                pend_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs to pipeline

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_uctx_idx  <= 4'h0;
            o_csa_we    <= 1'b0;
            o_csa_addr  <= `RST_WORD;
            o_csa_wdata <= `RST_WORD;
            o_pc_load   <= 1'b0;
            o_pc        <= `RST_WORD;
            o_int_ack   <= 1'b0;
            o_fatal     <= 1'b0;
            o_state     <= ST_IDLE;
        end else begin
            o_state    <= state_reg;
            o_fatal    <= fcu_reg;
            o_int_ack  <= int_ok;
            o_uctx_idx <= (state_reg == ST_SAVE) ? idx_reg + 4'h1 : 4'h0;
            o_csa_we   <= (state_reg == ST_SAVE) & ~save_fail;
            o_csa_addr <= fcx_reg + 32'({idx_reg, 2'b00});
            if ((kind_reg == KIND_TRAP) & (idx_reg == `TIN_WORD)) begin
                o_csa_wdata <= 32'(tid_reg);
            end else begin
                o_csa_wdata <= i_uctx_data;
            end
            o_pc_load <= (state_reg == ST_VECTOR) | ((state_reg == ST_IDLE) & i_rfe & ~trap_now);
            if (state_reg == ST_VECTOR) begin
                o_pc <= ((kind_reg == KIND_TRAP) ? tvb_reg : ivb_reg) | off_reg;
            end else begin
                o_pc <= i_rfe_ret;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: writes zero-wait, reads one wait state

    always_comb begin
        unique case (addr_q_reg)
            `IDX_ICR:      rd_mux = 32'({ie_reg, current_cpu_priority_reg});
            `IDX_TVB:      rd_mux = tvb_reg;
            `IDX_IVB:      rd_mux = ivb_reg;
            `IDX_FCX:      rd_mux = fcx_reg;
            `IDX_PREVIOUS_CONTEXT_INFO:     rd_mux = previous_context_info_reg;
            `IDX_RA:       rd_mux = ra_reg;
            `IDX_TID:      rd_mux = 32'(tid_reg);
            `IDX_SRC:      rd_mux = 32'({pend_reg, 7'h00, pend_prio_reg});
            `IDX_STATE:    rd_mux = 32'({imprecise_reg, fcu_reg, kind_reg, state_reg});
            `IDX_IRQ_STAT: rd_mux = 32'(ev_status);
            `IDX_IRQ_EN:   rd_mux = 32'(ev_enable);
            default:       rd_mux = `RST_WORD;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            addr_q_reg  <= 6'h00;
            wr_q_reg    <= 1'b0;
            rd_q_reg    <= 1'b0;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            o_hrdata    <= `RST_WORD;
        end else begin
            o_hresp  <= 1'b0;
            wr_q_reg <= ahb_take & i_hwrite;
            rd_q_reg <= ahb_take & ~i_hwrite;
            if (ahb_take) begin
                addr_q_reg <= i_haddr[7:2];
            end
            // the wait state lets a read see a write from the previous transfer
            o_hreadyout <= ~(ahb_take & ~i_hwrite);
            if (rd_q_reg) begin
                o_hrdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: trap taken, failure, interrupt taken, imprecise

    assign ev_set = {fcu_entry & cause_hit, int_ok, fcu_entry | save_fail, trap_entry};

    sticky_irq #(
        .W (`EV_WIDTH)
    ) u_irq (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_set      (ev_set),
        .i_clr      (wr_q_reg & (addr_q_reg == `IDX_IRQ_CLR) ? i_hwdata[`EV_WIDTH-1:0] : '0),
        .i_en_wr    (wr_q_reg & (addr_q_reg == `IDX_IRQ_EN)),
        .i_en_data  (i_hwdata[`EV_WIDTH-1:0]),
        .o_status   (ev_status),
        .o_enable   (ev_enable),
        .o_irq      (o_irq)
    );
endmodule

// ---- srq_node.sv ----
`timescale 1ns/10ps
module srq_node (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic       i_fire,
    input  wire logic [7:0] i_prio,
    output logic            o_req,
    output logic      [7:0] o_prio
);
    // one-cycle request per fire; idle priority lines toggle so stale values never look valid
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_req  <= 1'b0;
            o_prio <= 8'h00;
        end else begin
            o_req  <= i_fire;
            o_prio <= i_fire ? i_prio : ~o_prio;
        end
    end
endmodule

// ---- trap_entry_checker_asserts.sv ----
`timescale 1ns/10ps
module trap_entry_checker (
    input wire logic                         i_core_clk,
    input wire logic                         i_rst,
    input wire logic                         i_trap_req,
    input wire logic                         i_ctx_fail,
    input wire logic                         i_rfe,
    input wire logic [31:0]                  i_rfe_ret,
    input wire logic                         i_csa_err,
    input wire logic                         o_csa_we,
    input wire logic [31:0]                  o_csa_addr,
    input wire logic                         o_pc_load,
    input wire logic [31:0]                  o_pc,
    input wire logic                         o_fatal,
    input wire trap_entry_pkg::entry_state_t o_state,
    input wire logic                         o_int_ack
);
    import trap_entry_pkg::*;
    logic [4:0] we_cnt;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // length of the current save burst, read on the cycle it ends
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            we_cnt <= 5'h00;
        end else begin
            we_cnt <= o_csa_we ? we_cnt + 5'h01 : 5'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_fatal_hold; o_fatal |=> o_fatal; endproperty
    a_fatal_hold: assert property (p_fatal_hold) else $error("fatal dropped");
    property p_fatal_quiet; o_fatal |-> !o_csa_we && !o_int_ack; endproperty
    a_fatal_quiet: assert property (p_fatal_quiet) else $error("activity when fatal");
    property p_trap_blk; i_trap_req && o_state == ST_IDLE |=> !o_int_ack [*8]; endproperty
    a_trap_blk: assert property (p_trap_blk) else $error("ack in trap entry");
    // o_state trails the sequencer by one cycle, as o_int_ack does
    property p_ack_start;
        o_int_ack |=> o_state == ST_SAVE && $past(o_state) == ST_IDLE;
    endproperty
    a_ack_start: assert property (p_ack_start) else $error("ack mid entry");
    property p_save_len; $fell(o_csa_we) && !$past(i_csa_err) |-> we_cnt == 5'h10; endproperty
    a_save_len: assert property (p_save_len) else $error("save length");
    property p_addr_step;
        o_csa_we && $past(o_csa_we) |-> o_csa_addr == $past(o_csa_addr) + 32'h4;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("save address step");
    property p_vec_after; $fell(o_csa_we) && !$past(i_csa_err) |-> o_pc_load; endproperty
    a_vec_after: assert property (p_vec_after) else $error("vector not after save");
    property p_rfe_ret;
        i_rfe && o_state == ST_IDLE && !i_trap_req && !i_ctx_fail
            |=> o_pc_load && o_pc == $past(i_rfe_ret);
    endproperty
    a_rfe_ret: assert property (p_rfe_ret) else $error("return target");
    property p_rfe_quiet; i_rfe && o_state == ST_IDLE |=> !o_int_ack [*2]; endproperty
    a_rfe_quiet: assert property (p_rfe_quiet) else $error("ack after return");
    property p_ctx_fail; i_ctx_fail && o_state == ST_IDLE |-> ##[1:4] o_fatal; endproperty
    a_ctx_fail: assert property (p_ctx_fail) else $error("no failure trap");
    c_save: cover property ($fell(o_csa_we));
    c_ack: cover property (o_int_ack);
    c_fatal: cover property ($rose(o_fatal));
endmodule
bind trap_interrupt_entry_control trap_entry_checker chk_i (.i_core_clk, .i_rst, .i_trap_req,
    .i_ctx_fail, .i_rfe, .i_rfe_ret, .i_csa_err, .o_csa_we, .o_csa_addr, .o_pc_load, .o_pc,
    .o_fatal, .o_state, .o_int_ack);

// ---- testbench.sv ----
`timescale 1ns/10ps
`include "trap_entry_map.svh"
module testbench;
    import trap_entry_pkg::*;
    logic i_core_clk, i_rst, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, i_epc, i_rfe_ret, i_uctx_data;
    logic [31:0] i_csa_link, o_csa_addr, o_csa_wdata, o_pc;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize, i_trap_class;
    logic i_trap_req, i_ctx_fail, i_rfe, i_rfe_pie, i_csa_err, i_nmi_pin, i_srq_req;
    logic [7:0] i_trap_tin, i_rfe_current_cpu_priority, i_srq_prio, fprio;
    logic [4:0] i_trap_cause;
    logic [3:0] o_uctx_idx;
    logic o_csa_we, o_pc_load, o_fatal, o_int_ack, o_irq, fire;
    entry_state_t o_state;
    logic [31:0] ad[$];
    logic [31:0] dt[$];
    int num_errors, num_checks, acks, loads;
    assign i_hready = o_hreadyout;
    // pipeline side: upper context word k reads back as k
    assign i_uctx_data = {28'h0, o_uctx_idx};
    trap_interrupt_entry_control uut (.*);
    srq_node node (.i_core_clk, .i_rst, .i_fire(fire), .i_prio(fprio), .o_req(i_srq_req),
        .o_prio(i_srq_prio));
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report;
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic rdy;
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 20);
        if (o_hreadyout !== 1'b1) begin
            num_errors++;
            final_report;
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] ix, input logic [31:0] d,
                       output logic [31:0] q);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= {24'h0, ix, 2'h0};
        i_hwrite <= w;
        rdy;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        rdy;
        q = o_hrdata;
    endtask
    task automatic wr(input logic [5:0] ix, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, ix, d, q);
    endtask
    task automatic rd(input logic [5:0] ix, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, ix, 32'h0, q);
        chk(q & m, e);
        chk(o_hresp, 1'b0);
    endtask
    // runs until the next pc load, logging save writes and acks on the way
    task automatic entry(input int lim);
        int n;
        n = 0;
        acks = 0;
        ad = {};
        dt = {};
        do begin
            @(posedge i_core_clk);
            n++;
            if (o_csa_we === 1'b1) begin
                ad.push_back(o_csa_addr);
                dt.push_back(o_csa_wdata);
            end
            if (o_int_ack === 1'b1) acks++;
        end while (o_pc_load !== 1'b1 && n < lim);
        if (o_pc_load !== 1'b1) begin
            num_errors++;
            final_report;
        end
    endtask
    task automatic idle(input int c);
        acks = 0;
        loads = 0;
        repeat (c) begin
            @(posedge i_core_clk);
            acks += int'(o_int_ack === 1'b1);
            loads += int'(o_pc_load === 1'b1);
        end
    endtask
    task automatic trap(input logic [2:0] c, input logic [7:0] trap_identification_number, input logic [4:0] cs);
        i_trap_class <= c;
        i_trap_tin <= trap_identification_number;
        i_trap_cause <= cs;
        i_trap_req <= 1'b1;
        @(posedge i_core_clk);
        i_trap_req <= 1'b0;
    endtask
    task automatic return_from_exception(input logic prior_interrupt_enable, input logic [31:0] ret);
        i_rfe_pie <= prior_interrupt_enable;
        i_rfe_ret <= ret;
        i_rfe <= 1'b1;
        @(posedge i_core_clk);
        i_rfe <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_trap;
        wr(`IDX_TVB, 32'h8000);
        wr(`IDX_IVB, 32'h10000);
        wr(`IDX_FCX, 32'h1000);
        wr(`IDX_IRQ_EN, 32'h1);
        wr(`IDX_ICR, 32'h100);
        i_epc <= 32'h4444;
        fprio <= 8'h20;
        fire <= 1'b1;
        @(posedge i_core_clk);
        fire <= 1'b0;
        trap(3'h2, 8'h05, 5'h00);
        entry(40);
        chk(ad.size(), 16);
        foreach (ad[k]) chk(ad[k], 32'h1000 + 4 * k);
        chk(dt[15], 32'h5);
        chk(acks, 0);
        chk(o_pc, 32'h8040);
        rd(`IDX_PREVIOUS_CONTEXT_INFO, 32'h80_0000, 32'h80_0000);
        rd(`IDX_RA, 32'h4444, 32'hffff_ffff);
        rd(`IDX_ICR, 32'h0, 32'hffff_ffff);
        rd(`IDX_TID, 32'h5, 32'hff);
        chk(o_irq, 1'b1);
        wr(`IDX_IRQ_CLR, 32'h1);
        idle(2);
        chk(o_irq, 1'b0);
        return_from_exception(1'b0, 32'h8040);
        entry(4);
        chk(o_pc, 32'h8040);
        idle(10);
        chk(acks, 0);
        return_from_exception(1'b1, 32'h8040);
        entry(4);
        entry(40);
        chk(o_pc, 32'h10400);
        chk(acks, 1);
        chk(ad[0], 32'h2000);
        chk(dt[15], 32'hf);
    endtask
    task automatic t_prio;
        wr(`IDX_ICR, 32'h130);
        wr(`IDX_SRC, 32'h8030);
        idle(8);
        chk(acks, 0);
        rd(`IDX_SRC, 32'h8030, 32'h80ff);
        wr(`IDX_ICR, 32'h12f);
        entry(40);
        chk(o_pc, 32'h10600);
        i_nmi_pin <= 1'b1;
        entry(40);
        chk(o_pc, 32'h80e0);
        i_nmi_pin <= 1'b0;
    endtask
    task automatic t_fail;
        wr(`IDX_IRQ_EN, 32'ha);
        wr(`IDX_FCX, 32'h0);
        trap(3'h1, 8'h01, 5'h02);
        entry(8);
        chk(o_pc, 32'h8060);
        idle(2);
        chk(o_fatal, 1'b1);
        rd(`IDX_STATE, 32'h1b, 32'h1b);
        rd(`IDX_IRQ_STAT, 32'ha, 32'ha);
        chk(o_irq, 1'b1);
        wr(`IDX_IRQ_CLR, 32'ha);
        idle(2);
        chk(o_irq, 1'b0);
        trap(3'h1, 8'h01, 5'h00);
        idle(25);
        chk(loads, 0);
        // second reset; a failed restore must still end in the failure trap
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        chk(o_fatal, 1'b0);
        i_ctx_fail <= 1'b1;
        @(posedge i_core_clk);
        i_ctx_fail <= 1'b0;
        entry(8);
        chk(o_pc, 32'h60);
        idle(2);
        chk(o_fatal, 1'b1);
        // third reset; an error on a save write aborts the frame into the failure trap
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        wr(`IDX_FCX, 32'h1000);
        trap(3'h1, 8'h01, 5'h00);
        idle(3);
        i_csa_err <= 1'b1;
        @(posedge i_core_clk);
        i_csa_err <= 1'b0;
        entry(8);
        chk(o_pc, 32'h60);
        idle(2);
        chk(o_fatal, 1'b1);
    endtask
    initial begin
        {i_hsel, i_hwrite, i_trap_req, i_ctx_fail, i_rfe, i_rfe_pie} = '0;
        {i_csa_err, i_nmi_pin, fire, i_htrans, i_trap_class, i_trap_cause} = '0;
        {i_haddr, i_hwdata, i_epc, i_rfe_ret, i_trap_tin, i_rfe_current_cpu_priority, fprio} = '0;
        i_hsize = 3'h2;
        i_csa_link = 32'h2000;
        i_rst = 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        rd(`IDX_ICR, 32'h0, 32'hffff_ffff);
        rd(`IDX_FCX, 32'h0, 32'hffff_ffff);
        rd(6'h0f, 32'h0, 32'hffff_ffff);
        t_trap;
        t_prio;
        t_fail;
        final_report;
    end
endmodule
